/* rtl/mcd_pkg.sv */
// Constants and state layout for the machine-check and debug interrupt classes.
//
// Behaviour
// [RULE1] Machine check spares critical regs and syndrome.
// [RULE2] Machine-check return restores address and state.
// [RULE3] Other returns never touch machine-check save regs.
// [RULE4] Machine-check return acts at final execute stage.
// [RULE5] Machine-check cause and recoverability logged separately.
// [RULE6] Machine check taken only while enable bit set.
// [RULE7] Machine check owns its own save pair.
// [RULE8] Machine-check regs at register numbers 570-572.
// [RULE9] Debug entry saves current or next address.
// [RULE10] Debug return fetches from saved debug address.
// [RULE11] Debug entry copies whole machine state.
// [RULE12] Debug return restores machine state from save.
// [RULE13] Reserved state bits stay reserved in debug save.
// [RULE14] Debug is its own class with own regs.
// [RULE15] Class enable bit reverts debug to critical class.
// [RULE16] Status bit 57 records enabled critical interrupt.
// [RULE17] Status bit 58 records enabled critical return.
// [RULE18] Control bit 57 enables critical-taken events.
// [RULE19] Control bit 58 enables critical-return events.
// [RULE20] Debug taken: no higher exception, request, enable.
// [RULE21] Debug entry state: keep enable, mode from icm.
// [RULE22] Debug entry leaves critical save regs alone.
// [RULE23] Debug vector is prefix, offset, four zeros.
// [RULE24] Machine-check entry saves address and machine state.
package mcd_pkg;
    // -------------------------------------------------------------------
    // Special-purpose register numbers.
    // -------------------------------------------------------------------
    localparam logic [9:0] SPR_MC_SAVED_PC = 10'h023a;
    localparam logic [9:0] SPR_MC_SAVED_STATE = 10'h023b;
    localparam logic [9:0] SPR_MC_SYNDROME = 10'h023c;
    localparam logic [9:0] SPR_DEBUG_SAVED_PC = 10'h023e;
    localparam logic [9:0] SPR_DEBUG_SAVED_STATE = 10'h023f;
    localparam logic [9:0] SPR_DEBUG_STATUS = 10'h0130;
    localparam logic [9:0] SPR_DEBUG_CONTROL0 = 10'h0134;
    localparam logic [9:0] SPR_HW_IMPL0 = 10'h03f0;

    // -------------------------------------------------------------------
    // Field positions, little-endian index (big-endian bit n is 63 - n).
    // -------------------------------------------------------------------
    localparam int CRIT_TAKEN_BIT = 63 - 57;
    localparam int CRIT_RETURN_BIT = 63 - 58;
    localparam int CLASS_ENABLE_BIT = 63 - 49;
    localparam int MS_COMP_MODE_BIT = 63 - 32;
    localparam int MS_INT_COMP_MODE_BIT = 63 - 33;
    localparam int MS_MC_ENABLE_BIT = 63 - 51;
    localparam int MS_DBG_ENABLE_BIT = 63 - 54;
    localparam int SYN_RECOVERABLE_BIT = 63;
    localparam logic [63:0] MS_DEFINED_MASK = 64'h0000_0000_ffff_ffff;

    // -------------------------------------------------------------------
    // Register state of the unit and its reset value.
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [63:0] mcSavedPc;
        logic [63:0] mcSavedState;
        logic [63:0] mcSyndrome;
        logic [63:0] dbgSavedPc;
        logic [63:0] dbgSavedState;
        logic [1:0] ctlEvents;
        logic classEnable;
        logic redirectValid;
        logic [63:0] redirectPc;
        logic msrLoad;
        logic [63:0] msrNext;
        logic [63:0] rdData;
    } mcd_state_t;

    localparam mcd_state_t STATE_RESET = '{classEnable: 1'b1, default: '0};
endpackage : mcd_pkg

/* rtl/mcd_event_flags.sv */
// Sticky event flags where a hardware set always beats a software clear.
`timescale 1ns/10ps
`default_nettype none
module mcd_event_flags #(
    parameter int W = 2
) (
    input wire logic clk,           // Core clock.
    input wire logic srst,          // Synchronous reset, active high.
    input wire logic [W-1:0] setIn, // Event pulses, one per flag.
    input wire logic [W-1:0] clrIn, // Write-one-to-clear pulses.
    output logic [W-1:0] flags      // Registered sticky flags.
);
    typedef struct packed {
        logic [W-1:0] flags;
    } mcd_flag_state_t;

    mcd_flag_state_t st;
    mcd_flag_state_t next_st;

    // Clear first, then set, so an event in the clear cycle survives.
    always_comb begin
        next_st = st;
        next_st.flags = (st.flags & ~clrIn) | setIn;
    end

    // Register the flag state.
    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign flags = st.flags;

    set_wins_a: assert property (@(posedge clk) disable iff (srst)
        |setIn |=> ((flags & $past(setIn)) == $past(setIn)))
        else $error("event flag lost its set");
endmodule : mcd_event_flags
`default_nettype wire

/* rtl/mcd_dbg_entry.sv */
// Machine state and fetch address used on entry to the debug class.
`timescale 1ns/10ps
`default_nettype none
module mcd_dbg_entry (
    input wire logic [63:0] msrCur,       // Machine state at entry.
    input wire logic [63:0] vectorPrefix, // Vector prefix register.
    input wire logic [63:0] vectorOffset, // Debug vector offset register.
    output logic [63:0] entryMsr,         // Machine state in the handler.
    output logic [63:0] entryPc           // First handler fetch address.
);
    // Keep machine-check enable and icm, copy icm into the mode bit and
    // clear all else, so the handler starts with debug events masked.
    always_comb begin
        entryMsr = '0;                                           // [RULE21]
        entryMsr[mcd_pkg::MS_MC_ENABLE_BIT] =
            msrCur[mcd_pkg::MS_MC_ENABLE_BIT];
        entryMsr[mcd_pkg::MS_INT_COMP_MODE_BIT] =
            msrCur[mcd_pkg::MS_INT_COMP_MODE_BIT];
        entryMsr[mcd_pkg::MS_COMP_MODE_BIT] =
            msrCur[mcd_pkg::MS_INT_COMP_MODE_BIT];
    end

    // Prefix bits 0-47, offset bits 48-59 and a zero nibble.
    assign entryPc = {vectorPrefix[63:16], vectorOffset[15:4], 4'h0}; // [RULE23]
endmodule : mcd_dbg_entry
`default_nettype wire

/* rtl/mcd_exception_unit.sv */
// Machine-check and debug interrupt classes with their save registers.
`timescale 1ns/10ps
`default_nettype none
module mcd_exception_unit (
    input wire logic clk,                 // Core clock, 50 MHz.
    input wire logic srst,                // Synchronous reset, active high.
    input wire logic [63:0] msrCur,       // Current machine state.
    input wire logic [63:0] currPc,       // Interrupted or next address.
    input wire logic [63:0] vectorPrefix, // Interrupt vector prefix.
    input wire logic [63:0] debugVectorOffset, // Debug vector offset.
    input wire logic mcReq,               // Machine-check exception present.
    input wire logic [62:0] mcCause,      // Machine-check cause bits.
    input wire logic mcRecoverable,       // Machine check is recoverable.
    input wire logic dbgReq,              // Debug exception presented.
    input wire logic higherPending,       // Higher-priority exception exists.
    input wire logic critTaken,           // Core takes a critical interrupt.
    input wire logic retireRfmci,         // Machine-check return retires.
    input wire logic retireRfdi,          // Debug return retires.
    input wire logic retireRfci,          // Critical return retires.
    input wire logic sprWrEn,             // Register write strobe.
    input wire logic sprRdEn,             // Register read strobe.
    input wire logic [9:0] sprNum,        // Register number.
    input wire logic [63:0] sprWrData,    // Register write data.
    output logic [63:0] sprRdData,        // Read data, one cycle later.
    output logic mcTaken,                 // Machine check taken this cycle.
    output logic dbgTaken,                // Debug class interrupt taken.
    output logic dbgToCritical,           // Debug routed to critical class.
    output logic critHold,                // Core keeps critical regs now.
    output logic redirectValid,           // Fetch redirect pulse.
    output logic [63:0] redirectPc,       // Fetch redirect address.
    output logic msrLoad,                 // Machine state load pulse.
    output logic [63:0] msrNext           // Machine state to load.
);
    // -------------------------------------------------------------------
    // State and helpers.
    // -------------------------------------------------------------------
    mcd_pkg::mcd_state_t st;
    mcd_pkg::mcd_state_t next_st;
    logic mcTake;
    logic dbgEligible;
    logic dbgTake;
    logic [1:0] statusSet;
    logic [1:0] statusClr;
    logic [1:0] statusFlags;
    logic [63:0] entryMsr;
    logic [63:0] entryPc;
    logic [63:0] syndromeIn;

    // Read value of one register; unknown numbers read as zero.
    function automatic logic [63:0] sprRead(
        input logic [9:0] num,
        input mcd_pkg::mcd_state_t s,
        input logic [1:0] flagsIn
    );
        logic [63:0] v;
        v = '0;
        if (num == mcd_pkg::SPR_MC_SAVED_PC) begin
            v = s.mcSavedPc;
        end else if (num == mcd_pkg::SPR_MC_SAVED_STATE) begin
            v = s.mcSavedState;
        end else if (num == mcd_pkg::SPR_MC_SYNDROME) begin
            v = s.mcSyndrome;
        end else if (num == mcd_pkg::SPR_DEBUG_SAVED_PC) begin
            v = s.dbgSavedPc;
        end else if (num == mcd_pkg::SPR_DEBUG_SAVED_STATE) begin
            v = s.dbgSavedState & mcd_pkg::MS_DEFINED_MASK;
        end else if (num == mcd_pkg::SPR_DEBUG_STATUS) begin
            v[mcd_pkg::CRIT_TAKEN_BIT] = flagsIn[0];
            v[mcd_pkg::CRIT_RETURN_BIT] = flagsIn[1];
        end else if (num == mcd_pkg::SPR_DEBUG_CONTROL0) begin
            v[mcd_pkg::CRIT_TAKEN_BIT] = s.ctlEvents[0];
            v[mcd_pkg::CRIT_RETURN_BIT] = s.ctlEvents[1];
        end else if (num == mcd_pkg::SPR_HW_IMPL0) begin
            v[mcd_pkg::CLASS_ENABLE_BIT] = s.classEnable;
        end
        return v;
    endfunction : sprRead

    // True when a write strobe targets the given register.
    function automatic logic sprHit(
        input logic wr,
        input logic [9:0] num,
        input logic [9:0] target
    );
        return wr && (num == target);
    endfunction : sprHit

    // -------------------------------------------------------------------
    // Interrupt acceptance.
    // -------------------------------------------------------------------
    // Machine check outranks debug; both are gated by their state bits.
    assign mcTake = mcReq && msrCur[mcd_pkg::MS_MC_ENABLE_BIT];      // [RULE6]
    assign dbgEligible = dbgReq && !higherPending && !mcTake
        && msrCur[mcd_pkg::MS_DBG_ENABLE_BIT];                      // [RULE20]
    // With the class switched off the core handles debug as critical.
    assign dbgTake = dbgEligible && st.classEnable;          // [RULE14] [RULE15]
    assign dbgToCritical = dbgEligible && !st.classEnable;           // [RULE15]
    assign mcTaken = mcTake;
    assign dbgTaken = dbgTake;
    // Both classes own their save pair, so the core keeps its critical
    // save registers and syndrome untouched while either is entered.
    assign critHold = mcTake || dbgTake;          // [RULE1] [RULE7] [RULE22]
    assign syndromeIn = {mcRecoverable, mcCause};                     // [RULE5]

    // -------------------------------------------------------------------
    // Critical-class debug events.
    // -------------------------------------------------------------------
    // A critical entry counts whether it came from the core or from a
    // debug exception that fell back to the critical class.
    assign statusSet[0] = (critTaken || dbgToCritical)
        && st.ctlEvents[0];                             // [RULE16] [RULE18]
    assign statusSet[1] = retireRfci && st.ctlEvents[1]; // [RULE17] [RULE19]
    assign statusClr[0] = sprHit(sprWrEn, sprNum, mcd_pkg::SPR_DEBUG_STATUS)
        && sprWrData[mcd_pkg::CRIT_TAKEN_BIT];
    assign statusClr[1] = sprHit(sprWrEn, sprNum, mcd_pkg::SPR_DEBUG_STATUS)
        && sprWrData[mcd_pkg::CRIT_RETURN_BIT];

    mcd_event_flags #(
        .W(2)
    ) u_flags (
        .clk(clk),
        .srst(srst),
        .setIn(statusSet),
        .clrIn(statusClr),
        .flags(statusFlags)
    );

    mcd_dbg_entry u_entry (
        .msrCur(msrCur),
        .vectorPrefix(vectorPrefix),
        .vectorOffset(debugVectorOffset),
        .entryMsr(entryMsr),
        .entryPc(entryPc)
    );

    // -------------------------------------------------------------------
    // Next-state logic.
    // -------------------------------------------------------------------
    // Software writes come first so that a hardware capture in the same
    // cycle overrides them, except the syndrome, where the capture is ORed
    // into the written value; a lost save would corrupt the return path.
    always_comb begin
        next_st = st;
        next_st.redirectValid = 1'b0;
        next_st.msrLoad = 1'b0;
        if (sprHit(sprWrEn, sprNum, mcd_pkg::SPR_MC_SAVED_PC)) begin
            next_st.mcSavedPc = sprWrData;                            // [RULE8]
        end else if (sprHit(sprWrEn, sprNum,
                mcd_pkg::SPR_MC_SAVED_STATE)) begin
            next_st.mcSavedState = sprWrData;                         // [RULE8]
        end else if (sprHit(sprWrEn, sprNum, mcd_pkg::SPR_MC_SYNDROME)) begin
            next_st.mcSyndrome = sprWrData;                           // [RULE8]
        end else if (sprHit(sprWrEn, sprNum,
                mcd_pkg::SPR_DEBUG_SAVED_PC)) begin
            next_st.dbgSavedPc = sprWrData;
        end else if (sprHit(sprWrEn, sprNum,
                mcd_pkg::SPR_DEBUG_SAVED_STATE)) begin
            next_st.dbgSavedState = sprWrData
                & mcd_pkg::MS_DEFINED_MASK;                          // [RULE13]
        end else if (sprHit(sprWrEn, sprNum,
                mcd_pkg::SPR_DEBUG_CONTROL0)) begin
            next_st.ctlEvents[0] = sprWrData[mcd_pkg::CRIT_TAKEN_BIT];
            next_st.ctlEvents[1] = sprWrData[mcd_pkg::CRIT_RETURN_BIT];
        end else if (sprHit(sprWrEn, sprNum, mcd_pkg::SPR_HW_IMPL0)) begin
            next_st.classEnable = sprWrData[mcd_pkg::CLASS_ENABLE_BIT];
        end

        // Machine-check entry: only its own pair and syndrome change.
        if (mcTake) begin
            next_st.mcSavedPc = currPc;                              // [RULE24]
            next_st.mcSavedState = msrCur;                           // [RULE24]
            next_st.mcSyndrome = next_st.mcSyndrome | syndromeIn;     // [RULE5]
        end

        // Debug entry saves context, then vectors with a cleaned state.
        if (dbgTake) begin
            next_st.dbgSavedPc = currPc;                              // [RULE9]
            next_st.dbgSavedState = msrCur
                & mcd_pkg::MS_DEFINED_MASK;                 // [RULE11] [RULE13]
            next_st.redirectValid = 1'b1;
            next_st.redirectPc = entryPc;                            // [RULE23]
            next_st.msrLoad = 1'b1;
            next_st.msrNext = entryMsr;                              // [RULE21]
        end else if (!mcTake && retireRfmci) begin
            // The return reaches here only from the final execute stage,
            // so state and fetch change together after older work ends.
            next_st.redirectValid = 1'b1;                             // [RULE4]
            next_st.redirectPc = st.mcSavedPc;                        // [RULE2]
            next_st.msrLoad = 1'b1;
            next_st.msrNext = st.mcSavedState;                        // [RULE2]
        end else if (!mcTake && retireRfdi) begin           // [RULE3]
            // Word alignment of the fetch address drops the low two bits.
            next_st.redirectValid = 1'b1;
            next_st.redirectPc = {st.dbgSavedPc[63:2], 2'b00};       // [RULE10]
            next_st.msrLoad = 1'b1;
            next_st.msrNext = st.dbgSavedState;                      // [RULE12]
        end

        // Read data is captured at the strobe and held until the next.
        if (sprRdEn) begin
            next_st.rdData = sprRead(sprNum, st, statusFlags);
        end
    end

    // Register the whole unit state.
    always_ff @(posedge clk) begin
        if (srst) begin
            st <= mcd_pkg::STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // -------------------------------------------------------------------
    // Outputs.
    // -------------------------------------------------------------------
    assign sprRdData = st.rdData;
    assign redirectValid = st.redirectValid;
    assign redirectPc = st.redirectPc;
    assign msrLoad = st.msrLoad;
    assign msrNext = st.msrNext;

    // -------------------------------------------------------------------
    // Assertions.
    // -------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence mcReturnSeq;
        retireRfmci && !mcTake && !dbgTake;
    endsequence

    sequence mcRestoreSeq;
        redirectValid && msrLoad && (redirectPc == $past(st.mcSavedPc))
            && (msrNext == $past(st.mcSavedState));
    endsequence

    sequence dbgReturnSeq;
        retireRfdi && !retireRfmci && !mcTake && !dbgTake;
    endsequence

    sequence dbgRestoreSeq;
        redirectValid && msrLoad && (redirectPc[1:0] == 2'b00)
            && (redirectPc[63:2] == $past(st.dbgSavedPc[63:2]))
            && (msrNext == $past(st.dbgSavedState));
    endsequence

    mc_gate_a: assert property ( // [RULE6]
        mcTaken |-> msrCur[mcd_pkg::MS_MC_ENABLE_BIT])
        else $error("machine check taken while disabled");

    mc_save_a: assert property ( // [RULE24]
        mcTaken |=> (st.mcSavedPc == $past(currPc))
            && (st.mcSavedState == $past(msrCur)))
        else $error("machine check context not saved");

    mc_spare_crit_a: assert property ( // [RULE1]
        (mcTaken || dbgTaken) |-> critHold)
        else $error("critical registers not held on entry");

    mc_return_a: assert property ( // [RULE2]
        mcReturnSeq |=> mcRestoreSeq)
        else $error("machine check return restored wrong context");

    mc_keep_saves_a: assert property ( // [RULE3]
        retireRfci && !mcTaken && !sprWrEn
            |=> $stable(st.mcSavedPc) && $stable(st.mcSavedState))
        else $error("critical return changed machine check saves");

    mc_syndrome_a: assert property ( // [RULE5]
        mcTaken |=> st.mcSyndrome[mcd_pkg::SYN_RECOVERABLE_BIT]
            == ($past(mcRecoverable) || $past(sprWrEn && sprNum
            == mcd_pkg::SPR_MC_SYNDROME && sprWrData[63])
            || ($past(st.mcSyndrome[63]) && !$past(sprWrEn && sprNum
            == mcd_pkg::SPR_MC_SYNDROME))))
        else $error("recoverability not logged");

    dbg_gate_a: assert property ( // [RULE20]
        dbgTaken |-> dbgReq && !higherPending && !mcTaken
            && msrCur[mcd_pkg::MS_DBG_ENABLE_BIT])
        else $error("debug taken without its conditions");

    dbg_save_a: assert property ( // [RULE11]
        dbgTaken |=> (st.dbgSavedPc == $past(currPc))
            && (st.dbgSavedState == ($past(msrCur)
            & mcd_pkg::MS_DEFINED_MASK)))
        else $error("debug context not saved");

    dbg_entry_a: assert property ( // [RULE23]
        dbgTaken |=> redirectValid && msrLoad
            && (redirectPc[3:0] == 4'h0)
            && (msrNext[mcd_pkg::MS_COMP_MODE_BIT]
            == $past(msrCur[mcd_pkg::MS_INT_COMP_MODE_BIT]))
            && (msrNext[mcd_pkg::MS_DBG_ENABLE_BIT] == 1'b0))
        else $error("debug entry vector or state wrong");

    dbg_return_a: assert property ( // [RULE12]
        dbgReturnSeq |=> dbgRestoreSeq)
        else $error("debug return restored wrong context");

    dbg_class_a: assert property ( // [RULE15]
        dbgEligible |-> (dbgTaken != dbgToCritical)
            && (dbgTaken == st.classEnable))
        else $error("debug class routing wrong");

    crit_event_a: assert property ( // [RULE16]
        critTaken && st.ctlEvents[0] |=> statusFlags[0])
        else $error("critical taken event not recorded");

    crit_return_a: assert property ( // [RULE17]
        retireRfci && st.ctlEvents[1] |=> statusFlags[1])
        else $error("critical return event not recorded");

    event_off_a: assert property ( // [RULE18]
        !statusFlags[0] && !st.ctlEvents[0] && !dbgToCritical
            |=> !statusFlags[0])
        else $error("disabled critical event was recorded");

    mc_no_redirect_a: assert property ( // [RULE7]
        mcTaken |=> !redirectValid && !msrLoad)
        else $error("machine check entry redirected fetch");

    mc_cause_log_a: assert property ( // [RULE5]
        mcTaken |=> (st.mcSyndrome[62:0] & $past(mcCause))
            == $past(mcCause))
        else $error("machine check cause not logged");

    dbg_keep_mc_a: assert property ( // [RULE3]
        (retireRfdi || retireRfci) && !mcTaken && !sprWrEn
            |=> $stable(st.mcSavedPc) && $stable(st.mcSavedState))
        else $error("other return changed machine check saves");

    dbg_vector_a: assert property ( // [RULE23]
        dbgTaken |=> redirectPc == {$past(vectorPrefix[63:16]),
            $past(debugVectorOffset[15:4]), 4'h0})
        else $error("debug vector address wrong");

    dbg_entry_keep_a: assert property ( // [RULE21]
        dbgTaken |=> (msrNext[mcd_pkg::MS_MC_ENABLE_BIT]
            == $past(msrCur[mcd_pkg::MS_MC_ENABLE_BIT]))
            && (msrNext[mcd_pkg::MS_INT_COMP_MODE_BIT]
            == $past(msrCur[mcd_pkg::MS_INT_COMP_MODE_BIT])))
        else $error("debug entry lost kept state bits");

    redirect_pair_a: assert property ( // [RULE4]
        redirectValid == msrLoad)
        else $error("fetch redirect and state load split");
endmodule : mcd_exception_unit
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the machine-check and debug interrupt unit.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    // ---------------------------------------------------------------
    // Stimulus signals and scoreboard queues.
    // ---------------------------------------------------------------
    logic clk = 0, srst = 1, rec = 0, higher = 0, wEn = 0, rEn = 0;
    logic rdPend = 0;
    logic [63:0] msrCur = '0, currPc = '0, vPre = '0, vOff = '0, wData = '0;
    logic [62:0] cause = '0;
    logic [9:0] num = '0;
    logic [5:0] ev = '0; // Event pulses: mc, dbg, crit, rfmci, rfdi, rfci.
    logic [31:0] lf = 32'h0000_b296;
    logic [63:0] rdData, rPc, mNext;
    logic mT, dT, dC, cH, rV, mL;
    logic [63:0] rq[$], pq[$], sq[$], tq[$];
    int nErrors = 0, checks = 0;
    always #10 clk = ~clk;
    mcd_exception_unit mcd_exception_unit_inst (.clk(clk), .srst(srst),
        .msrCur(msrCur), .currPc(currPc), .vectorPrefix(vPre),
        .debugVectorOffset(vOff), .mcReq(ev[0]), .mcCause(cause),
        .mcRecoverable(rec), .dbgReq(ev[1]), .higherPending(higher),
        .critTaken(ev[2]), .retireRfmci(ev[3]), .retireRfdi(ev[4]),
        .retireRfci(ev[5]), .sprWrEn(wEn), .sprRdEn(rEn), .sprNum(num),
        .sprWrData(wData), .sprRdData(rdData), .mcTaken(mT), .dbgTaken(dT),
        .dbgToCritical(dC), .critHold(cH), .redirectValid(rV),
        .redirectPc(rPc), .msrLoad(mL), .msrNext(mNext));
    // 32-bit shift register source, two steps per call; the low half is the high half XOR a constant.
    function automatic logic [63:0] rnd();
        repeat (2) lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return {lf, lf ^ 32'h5a5a_a5a5};
    endfunction : rnd
    task automatic end_sim();
        if (nErrors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim
    task automatic cmp(input logic [63:0] g, ref logic [63:0] q[$]);
        logic [63:0] e;
        e = (q.size() > 0) ? q.pop_front() : 'x;
        checks++;
        if (g !== e) begin
            nErrors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : cmp
    // Each access lowers its strobe, then lets one edge pass.
    task automatic wr(input logic [9:0] n, input logic [63:0] d);
        wEn <= 1; num <= n; wData <= d; @(posedge clk);
        wEn <= 0; @(posedge clk);
    endtask : wr
    task automatic rd(input logic [9:0] n, input logic [63:0] e);
        rq.push_back(e); rEn <= 1; num <= n; @(posedge clk);
        rEn <= 0; @(posedge clk);
    endtask : rd
    task automatic pulse(input logic [5:0] v, input logic [2:0] t);
        tq.push_back({60'b0, t[2] | t[1], t}); ev <= v; @(posedge clk);
        ev <= '0; @(posedge clk);
    endtask : pulse
    // Watcher: results are settled by the falling edge.
    always @(posedge clk) rdPend <= rEn;
    always @(negedge clk) begin
        if (rdPend) cmp(rdData, rq);
        if (ev != '0) cmp({60'b0, cH, mT, dT, dC}, tq);
        if (rV) cmp(rPc, pq);
        if (rV) cmp(mNext, sq);
        if (rV !== mL) begin
            nErrors++;
            $display("unexpected at %0t: redirect and load split", $time);
        end
    end
    initial begin
        repeat (5000) @(posedge clk);
        nErrors++;
        end_sim();
    end
    // ---------------------------------------------------------------
    // Main sequence.
    // ---------------------------------------------------------------
    initial begin : main
        logic [63:0] m, p, d, e;
        logic [9:0] regs[5];
        regs = '{10'h023a, 10'h023b, 10'h023c, 10'h023e, 10'h023f};
        repeat (12) @(posedge clk);
        srst <= 0; vPre <= rnd(); vOff <= rnd(); @(posedge clk);
        rd(10'h03f0, 64'h0000_0000_0000_4000);
        rd(10'h0134, '0);
        foreach (regs[i]) begin
            d = rnd();
            wr(regs[i], d);
            e = (i == 4) ? (d & mcd_pkg::MS_DEFINED_MASK) : d;
            rd(regs[i], e);
        end
        rd(10'h0155, '0);
        wr(10'h023c, '0);
        // Machine check with the enable bit set.
        m = rnd() | 64'h0000_0000_0000_1000;
        p = rnd(); d = rnd();
        msrCur <= m; currPc <= p; cause <= d[62:0]; rec <= 1;
        pulse(6'b00_0001, 3'b100);
        rd(10'h023a, p);
        rd(10'h023b, m);
        rd(10'h023c, {1'b1, d[62:0]});
        // Neither class may enter while both enables are clear.
        msrCur <= m & ~64'h0000_0000_0000_1200; currPc <= ~p;
        pulse(6'b00_0011, 3'b000);
        pulse(6'b10_0000, 3'b000);
        rd(10'h023a, p);
        rd(10'h023b, m);
        pq.push_back(p); sq.push_back(m);
        pulse(6'b00_1000, 3'b000);
        // Debug entry, first held off by a higher exception.
        m = rnd() | 64'h0000_0000_0000_0200;
        p = rnd();
        msrCur <= m; currPc <= p; higher <= 1;
        pulse(6'b00_0010, 3'b000);
        higher <= 0;
        e = '0;
        e[12] = m[12]; e[30] = m[30]; e[31] = m[30];
        pq.push_back({vPre[63:16], vOff[15:4], 4'h0}); sq.push_back(e);
        pulse(6'b00_0010, 3'b010);
        rd(10'h023e, p);
        rd(10'h023f, m & mcd_pkg::MS_DEFINED_MASK);
        pq.push_back(p & ~64'h3); sq.push_back(m & mcd_pkg::MS_DEFINED_MASK);
        pulse(6'b01_0000, 3'b000);
        // Critical event flags, enabled and then disabled.
        wr(10'h0134, 64'h0000_0000_0000_0060);
        pulse(6'b00_0100, 3'b000);
        pulse(6'b10_0000, 3'b000);
        rd(10'h0130, 64'h0000_0000_0000_0060);
        wr(10'h0130, 64'h0000_0000_0000_0060);
        wr(10'h0134, '0);
        pulse(6'b00_0100, 3'b000);
        pulse(6'b10_0000, 3'b000);
        rd(10'h0130, '0);
        // Class disabled: debug falls back to the critical class.
        wr(10'h0134, 64'h0000_0000_0000_0040);
        wr(10'h03f0, '0);
        pulse(6'b00_0010, 3'b001);
        rd(10'h0130, 64'h0000_0000_0000_0040);
        // Any note still queued is a result that never appeared.
        if (rq.size() + pq.size() + sq.size() + tq.size() != 0) begin
            nErrors++;
            $display("unexpected at %0t: results never seen", $time);
        end
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
